// *** sdcc_pkg.sv ***
// Purpose: Shared constants for the delta-sigma conversion control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Result words are 24 bits wide.
package sdcc_pkg;
	localparam int          ADDR_W         = 8;
	localparam int          RES_W          = 24;
	localparam int          RAW_W          = 25;

	// Register byte addresses.
	localparam logic [7:0]  CTRL_ADDR      = 8'h00;
	localparam logic [7:0]  STAT_ADDR      = 8'h04;
	localparam logic [7:0]  SLOW_ADDR      = 8'h08;
	localparam logic [7:0]  QUICK_ADDR     = 8'h0C;
	localparam logic [7:0]  DAC_ADDR       = 8'h10;

	// Control register fields.
	localparam int          MODE_LSB       = 0;
	localparam int          ISEL_BIT       = 2;
	localparam int          BURN_BIT       = 3;
	localparam int          POL_BIT        = 4;
	localparam logic [4:0]  CTRL_RESET     = 5'h00;
	localparam logic [7:0]  DAC_RESET      = 8'h00;

	// Status register fields.
	localparam int          BUSY_BIT       = 0;
	localparam int          DONE_BIT       = 1;
	localparam int          SCLIP_BIT      = 2;
	localparam int          QCLIP_BIT      = 3;
	localparam int          OVR_BIT        = 4;
	localparam int          ERR_BIT        = 5;
	localparam int          CALERR_BIT     = 6;

	// Conversion-mode field encodings.
	localparam logic [1:0]  MODE_IDLE      = 2'h0;
	localparam logic [1:0]  MODE_SINGLE    = 2'h1;
	localparam logic [1:0]  MODE_CONT      = 2'h2;

	// One conversion-cycle period in clocks, from the clock period and the conversion period in ns.
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          CONV_PERIOD_NS = 10000;
	localparam int          CONV_CYCLES    = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SLOW_PERIODS   = 3;

	typedef enum logic {SDCC_IDLE, SDCC_RUN} sdcc_state_t;
endpackage

// *** sdcc_top.sv ***
// Purpose: Conversion sequencing, result coding and error flags of a delta-sigma converter.
// Assumes: Filter data and overflow strobes arrive synchronous to pclk.
// Notes: APB slave with zero wait states; read data is captured in the setup phase.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps

module sdcc_top
	import sdcc_pkg::*;
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [sdcc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [sdcc_pkg::RAW_W-1:0]  slow_filter_data,
	input  wire logic [sdcc_pkg::RAW_W-1:0]  quick_filter_data,
	input  wire logic                        slow_filter_overflow,
	input  wire logic                        quick_filter_overflow,
	input  wire logic                        cal_limit_error,
	output logic                             conv_active,
	output logic                             burnout_enable,
	output logic                             dac_sign,
	output logic      [6:0]                  dac_magnitude,
	output logic                             dac_update
);
	import sdcc_pkg::*;

	// Raw filter words are signed, full scale +/-2^24 for +/-VREF.
	function automatic logic [RES_W-1:0] format_result(input logic [RAW_W-1:0] raw, input logic bipolar);
		logic [RAW_W-1:0] half;
		half = {raw[RAW_W-1], raw[RAW_W-1:1]};
		if (bipolar)
			format_result = half[RES_W-1:0];
		else if (raw[RAW_W-1])
			format_result = '0;
		else
			format_result = raw[RES_W-1:0];
	endfunction

	function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] target);
		is_addr = (a == target);
	endfunction

	sdcc_state_t       state_reg;
	logic [1:0]        conv_mode_field_reg;
	logic              irq_filter_select_reg;
	logic              burnout_enable_reg;
	logic              output_polarity_select_reg;
	logic [7:0]        offset_dac_setting_reg;
	logic              dac_update_reg;
	logic [9:0]        period_cnt_reg;
	logic [1:0]        cycle_idx_reg;
	logic              conv_done_flag_reg;
	logic              slow_filter_clip_flag_reg;
	logic              quick_filter_clip_flag_reg;
	logic              overrun_flag_reg;
	logic              cal_err_reg;
	logic [RES_W-1:0]  slow_result_reg;
	logic [RES_W-1:0]  quick_result_reg;
	logic [31:0]       prdata_reg;

	logic              wr_access;
	logic              setup;
	logic              mapped;
	logic              ctrl_wr;
	logic              stat_wr;
	logic [1:0]        mode_wr;
	logic              start_req;
	logic              stop_req;
	logic              running;
	logic              period_end;
	logic              quick_ready;
	logic              slow_ready;
	logic              conv_end;
	logic              any_error_flag;

	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign mapped    = is_addr(paddr, CTRL_ADDR) || is_addr(paddr, STAT_ADDR) || is_addr(paddr, SLOW_ADDR)
	                   || is_addr(paddr, QUICK_ADDR) || is_addr(paddr, DAC_ADDR);
	assign ctrl_wr   = wr_access && is_addr(paddr, CTRL_ADDR);
	assign stat_wr   = wr_access && is_addr(paddr, STAT_ADDR);
	assign mode_wr   = pwdata[MODE_LSB+1:MODE_LSB];
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;
	assign prdata    = prdata_reg;

	assign start_req = ctrl_wr && (mode_wr == MODE_SINGLE || mode_wr == MODE_CONT);
	// idle write stops
	// Any code other than single or continuous stops, so the mode field and the sequencer never disagree.
	assign stop_req  = ctrl_wr && !(mode_wr == MODE_SINGLE || mode_wr == MODE_CONT);
	assign running   = (state_reg == SDCC_RUN);

	assign period_end  = running && (period_cnt_reg == 10'(CONV_CYCLES - 1));
	assign quick_ready = period_end;
	// slow after three
	// A single conversion on the quick filter stops before the slow filter has settled.
	assign slow_ready  = period_end && (cycle_idx_reg >= 2'(SLOW_PERIODS - 1))
	                     && !(conv_mode_field_reg == MODE_SINGLE && irq_filter_select_reg);
	assign conv_end    = irq_filter_select_reg ? quick_ready : slow_ready;

	assign any_error_flag = slow_filter_clip_flag_reg || quick_filter_clip_flag_reg || overrun_flag_reg || cal_err_reg;

	assign conv_active    = running;
	assign burnout_enable = burnout_enable_reg;
	assign dac_sign       = offset_dac_setting_reg[7];
	assign dac_magnitude  = offset_dac_setting_reg[6:0];
	assign dac_update     = dac_update_reg;

	// Sequencer state.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= SDCC_IDLE;
		else if (stop_req)
			state_reg <= SDCC_IDLE;
		else if (start_req)
			state_reg <= SDCC_RUN;
		else
		begin
			case (state_reg)
				SDCC_IDLE: state_reg <= SDCC_IDLE;
				SDCC_RUN:
				begin
					if (conv_end && conv_mode_field_reg == MODE_SINGLE)
						state_reg <= SDCC_IDLE;
				end
				default: state_reg <= SDCC_IDLE;
			endcase
		end
	end

	// Period and cycle counters; a start restarts the sequence from scratch.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			period_cnt_reg <= '0;
			cycle_idx_reg  <= '0;
		end
		else if (start_req || !running)
		begin
			period_cnt_reg <= '0;
			cycle_idx_reg  <= '0;
		end
		else if (period_end)
		begin
			period_cnt_reg <= '0;
			if (cycle_idx_reg != 2'(SLOW_PERIODS - 1))
				cycle_idx_reg <= cycle_idx_reg + 2'h1;
		end
		else
			period_cnt_reg <= period_cnt_reg + 10'h001;
	end

	// Control register; the mode field also returns to idle by itself.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_mode_field_reg        <= CTRL_RESET[MODE_LSB+1:MODE_LSB];
			irq_filter_select_reg      <= CTRL_RESET[ISEL_BIT];
			burnout_enable_reg         <= CTRL_RESET[BURN_BIT];
			output_polarity_select_reg <= CTRL_RESET[POL_BIT];
		end
		else if (ctrl_wr)
		begin
			conv_mode_field_reg        <= (mode_wr == MODE_CONT || mode_wr == MODE_SINGLE) ? mode_wr : MODE_IDLE;
			irq_filter_select_reg      <= pwdata[ISEL_BIT];
			burnout_enable_reg         <= pwdata[BURN_BIT];
			output_polarity_select_reg <= pwdata[POL_BIT];
		end
		else if (conv_end && conv_mode_field_reg == MODE_SINGLE)
			conv_mode_field_reg <= MODE_IDLE;
	end

	// Offset DAC setting and its change strobe.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			offset_dac_setting_reg <= DAC_RESET;
			dac_update_reg         <= 1'b0;
		end
		else
		begin
			dac_update_reg <= wr_access && is_addr(paddr, DAC_ADDR);
			if (wr_access && is_addr(paddr, DAC_ADDR))
				offset_dac_setting_reg <= pwdata[7:0];
		end
	end

	// Result registers, written regardless of any error.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slow_result_reg  <= '0;
			quick_result_reg <= '0;
		end
		else
		begin
			if (quick_ready)
				quick_result_reg <= format_result(quick_filter_data, output_polarity_select_reg);
			if (slow_ready)
				slow_result_reg <= format_result(slow_filter_data, output_polarity_select_reg);
		end
	end

	// Sticky flags, cleared by writing one; a new event wins over the clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_done_flag_reg         <= 1'b0;
			slow_filter_clip_flag_reg  <= 1'b0;
			quick_filter_clip_flag_reg <= 1'b0;
			overrun_flag_reg           <= 1'b0;
			cal_err_reg                <= 1'b0;
		end
		else
		begin
			if (conv_end)
				conv_done_flag_reg <= 1'b1;
			else if (stat_wr && pwdata[DONE_BIT])
				conv_done_flag_reg <= 1'b0;
			if (running && slow_filter_overflow)
				slow_filter_clip_flag_reg <= 1'b1;
			else if (stat_wr && pwdata[SCLIP_BIT])
				slow_filter_clip_flag_reg <= 1'b0;
			if (running && quick_filter_overflow)
				quick_filter_clip_flag_reg <= 1'b1;
			else if (stat_wr && pwdata[QCLIP_BIT])
				quick_filter_clip_flag_reg <= 1'b0;
			if (conv_end && conv_done_flag_reg)
				overrun_flag_reg <= 1'b1;
			else if (stat_wr && pwdata[OVR_BIT])
				overrun_flag_reg <= 1'b0;
			if (cal_limit_error)
				cal_err_reg <= 1'b1;
			else if (stat_wr && pwdata[CALERR_BIT])
				cal_err_reg <= 1'b0;
		end
	end

	// Read data is captured in the setup phase so that prdata comes from a flip-flop.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= '0;
		else if (setup && !pwrite)
		begin
			prdata_reg <= '0;
			if (is_addr(paddr, CTRL_ADDR))
				prdata_reg <= {27'h0000000, output_polarity_select_reg, burnout_enable_reg,
				               irq_filter_select_reg, conv_mode_field_reg};
			else if (is_addr(paddr, STAT_ADDR))
				prdata_reg <= {25'h0000000, cal_err_reg, any_error_flag, overrun_flag_reg,
				               quick_filter_clip_flag_reg, slow_filter_clip_flag_reg, conv_done_flag_reg, running};
			else if (is_addr(paddr, SLOW_ADDR))
				prdata_reg <= {8'h00, slow_result_reg};
			else if (is_addr(paddr, QUICK_ADDR))
				prdata_reg <= {8'h00, quick_result_reg};
			else if (is_addr(paddr, DAC_ADDR))
				prdata_reg <= {24'h000000, offset_dac_setting_reg};
		end
	end

	// Cycles since the last start, for timing checks only.
	logic [11:0] elapsed_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			elapsed_reg <= '0;
		else if (start_req)
			elapsed_reg <= '0;
		else if (elapsed_reg != 12'hFFF)
			elapsed_reg <= elapsed_reg + 12'h001;
	end

	property p_busy_start;
		@(posedge pclk) disable iff (!presetn) start_req |=> conv_active ##0 $past(mode_wr) == conv_mode_field_reg;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not set after start");

	property p_quick_first;
		@(posedge pclk) disable iff (!presetn)
			quick_ready && cycle_idx_reg == 2'h0 |-> elapsed_reg == 12'(CONV_CYCLES - 1);
	endproperty
	a_quick_first: assert property (p_quick_first) else $error("first quick result at wrong time");

	property p_slow_first;
		@(posedge pclk) disable iff (!presetn)
			slow_ready && elapsed_reg < 12'(SLOW_PERIODS * CONV_CYCLES) |-> elapsed_reg == 12'(SLOW_PERIODS * CONV_CYCLES - 1);
	endproperty
	a_slow_first: assert property (p_slow_first) else $error("first slow result at wrong time");

	property p_single_end;
		@(posedge pclk) disable iff (!presetn)
			conv_end && conv_mode_field_reg == MODE_SINGLE && !ctrl_wr |=> !conv_active && conv_mode_field_reg == MODE_IDLE;
	endproperty
	a_single_end: assert property (p_single_end) else $error("single conversion did not return to idle");

	property p_cont_go;
		@(posedge pclk) disable iff (!presetn)
			conv_end && conv_mode_field_reg == MODE_CONT && !ctrl_wr |=> conv_active ##1 (conv_active || $past(stop_req));
	endproperty
	a_cont_go: assert property (p_cont_go) else $error("continuous mode stopped");

	property p_done_set;
		@(posedge pclk) disable iff (!presetn)
			(irq_filter_select_reg ? quick_ready : slow_ready) |=> conv_done_flag_reg;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done flag not set");

	property p_overrun;
		@(posedge pclk) disable iff (!presetn) conv_end && conv_done_flag_reg |=> overrun_flag_reg && any_error_flag;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_quick_data;
		@(posedge pclk) disable iff (!presetn)
			quick_ready |=> quick_result_reg == format_result($past(quick_filter_data), $past(output_polarity_select_reg));
	endproperty
	a_quick_data: assert property (p_quick_data) else $error("quick result not updated");

	property p_unipolar_floor;
		@(posedge pclk) disable iff (!presetn)
			slow_ready && !output_polarity_select_reg && slow_filter_data[RAW_W-1] |=> slow_result_reg == 24'h000000;
	endproperty
	a_unipolar_floor: assert property (p_unipolar_floor) else $error("unipolar code below zero");

	property p_quick_floor;
		@(posedge pclk) disable iff (!presetn)
			quick_ready && !output_polarity_select_reg && quick_filter_data[RAW_W-1] |=> quick_result_reg == 24'h000000;
	endproperty
	a_quick_floor: assert property (p_quick_floor) else $error("unipolar quick code below zero");

	property p_bipolar_sign;
		@(posedge pclk) disable iff (!presetn)
			quick_ready && output_polarity_select_reg |=> quick_result_reg[RES_W-1] == $past(quick_filter_data[RAW_W-1]);
	endproperty
	a_bipolar_sign: assert property (p_bipolar_sign) else $error("bipolar sign lost");

	property p_slow_clip;
		@(posedge pclk) disable iff (!presetn) running && slow_filter_overflow |=> slow_filter_clip_flag_reg
			##1 (slow_filter_clip_flag_reg || $past(stat_wr && pwdata[SCLIP_BIT]));
	endproperty
	a_slow_clip: assert property (p_slow_clip) else $error("slow clip flag not held");

	property p_dac;
		@(posedge pclk) disable iff (!presetn)
			wr_access && is_addr(paddr, DAC_ADDR) |=> dac_update && {dac_sign, dac_magnitude} == $past(pwdata[7:0]);
	endproperty
	a_dac: assert property (p_dac) else $error("offset DAC write not applied");

	property p_burnout;
		@(posedge pclk) disable iff (!presetn) ctrl_wr |=> burnout_enable == $past(pwdata[BURN_BIT]);
	endproperty
	a_burnout: assert property (p_burnout) else $error("burnout enable mismatch");

	c_single_slow: cover property (@(posedge pclk) disable iff (!presetn)
		slow_ready && conv_mode_field_reg == MODE_SINGLE);
	c_cont_slow: cover property (@(posedge pclk) disable iff (!presetn)
		slow_ready && conv_mode_field_reg == MODE_CONT ##[1:1000] slow_ready);
	c_overrun: cover property (@(posedge pclk) disable iff (!presetn) conv_end && conv_done_flag_reg);
	c_dac_write: cover property (@(posedge pclk) disable iff (!presetn) dac_update);
endmodule

// *** tb_sdcc_top.sv ***
// Purpose: Self-checking bench for the delta-sigma conversion control block.
// Assumes: Zero-wait APB slave; one conversion period is CONV_CYCLES clocks.
// Notes: Expected codes come from a small model here, never from the design.
`timescale 1ns/1ps
module tb_sdcc_top;
	import sdcc_pkg::*;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [RAW_W-1:0]  slow_d;
	logic [RAW_W-1:0]  quick_d;
	logic              slow_ovf;
	logic              quick_ovf;
	logic              cal_err;
	logic              conv_active;
	logic              burnout_enable;
	logic              dac_sign;
	logic [6:0]        dac_magnitude;
	logic              dac_update;
	int                bad_count;
	int                compares;
	int                seed;
	int                n;
	logic [31:0]       rd;
	logic [31:0]       v;
	logic              e;
	logic [24:0]       traw [7];
	logic              tpol [7];
	logic [23:0]       texp [7];

	sdcc_top u_sdcc_top (
		.pclk                  (pclk),
		.presetn               (presetn),
		.psel                  (psel),
		.penable               (penable),
		.pwrite                (pwrite),
		.paddr                 (paddr),
		.pwdata                (pwdata),
		.prdata                (prdata),
		.pready                (pready),
		.pslverr               (pslverr),
		.slow_filter_data      (slow_d),
		.quick_filter_data     (quick_d),
		.slow_filter_overflow  (slow_ovf),
		.quick_filter_overflow (quick_ovf),
		.cal_limit_error       (cal_err),
		.conv_active           (conv_active),
		.burnout_enable        (burnout_enable),
		.dac_sign              (dac_sign),
		.dac_magnitude         (dac_magnitude),
		.dac_update            (dac_update)
	);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic close_out();
		$display("COUNTS compares=%0d bad=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Each call starts one edge later, so psel is never assigned twice in one step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic er);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			bad_count++;
			close_out();
		end
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        y;
		apb(1'b1, a, d, x, y);
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic y;
		apb(1'b0, a, 32'h0, rd, y);
		chk(what, exp, rd);
	endtask

	// Counts edges from the starting write until busy falls.
	task automatic run_wait(input int exp_n);
		n = 0;
		do
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		while (conv_active === 1'b1 && n < 5000);
		if (n >= 5000)
		begin
			bad_count++;
			close_out();
		end
		chk("busy cycles", exp_n, n);
	endtask

	task automatic pulse(input int which);
		@(posedge pclk);
		slow_ovf <= (which == 0);
		quick_ovf <= (which == 1);
		cal_err <= (which == 2);
		@(posedge pclk);
		slow_ovf <= 1'b0;
		quick_ovf <= 1'b0;
		cal_err <= 1'b0;
	endtask

	task automatic new_data();
		@(posedge pclk);
		slow_d <= RAW_W'($random(seed));
		quick_d <= RAW_W'($random(seed));
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] m, input logic is, input logic b, input logic p);
		return {27'h0, p, b, is, m};
	endfunction

	// Unipolar clamps negative words to zero; bipolar halves the signed word.
	function automatic logic [31:0] code(input logic [24:0] raw, input logic p);
		if (p)
			return {8'h00, raw[24:1]};
		return raw[24] ? 32'h0 : {8'h00, raw[23:0]};
	endfunction

	initial
	begin
		seed = 73;
		bad_count = 0;
		compares = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		slow_d = 25'h0;
		quick_d = 25'h0;
		slow_ovf = 1'b0;
		quick_ovf = 1'b0;
		cal_err = 1'b0;
		traw = '{25'h0800000, 25'h0000001, 25'h0000000, 25'h0FFFFFE, 25'h1800000, 25'h1000000, 25'h1FFFFFF};
		tpol = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		texp = '{24'h800000, 24'h000001, 24'h000000, 24'h7FFFFF, 24'hC00000, 24'h800000, 24'h000000};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctrl reset", CTRL_ADDR, 32'h0);
		rdc("status reset", STAT_ADDR, 32'h0);
		rdc("dac reset", DAC_ADDR, 32'h0);
		chk("busy reset", 32'h0, {31'h0, conv_active});
		$display("TEST reset finished");
		v = {24'h0, 8'($random(seed))};
		wr(DAC_ADDR, v);
		#1;
		chk("dac update", 32'h1, {31'h0, dac_update});
		chk("dac sign", {31'h0, v[7]}, {31'h0, dac_sign});
		chk("dac magnitude", {25'h0, v[6:0]}, {25'h0, dac_magnitude});
		@(posedge pclk);
		#1;
		chk("dac update low", 32'h0, {31'h0, dac_update});
		wr(8'h20, 32'hFF);
		rdc("dac kept", DAC_ADDR, v);
		apb(1'b0, 8'h20, 32'h0, rd, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, rd);
		wr(CTRL_ADDR, ctl(2'h0, 1'b0, 1'b1, 1'b0));
		#1;
		chk("burnout on", 32'h1, {31'h0, burnout_enable});
		wr(CTRL_ADDR, 32'h0);
		#1;
		chk("burnout off", 32'h0, {31'h0, burnout_enable});
		wr(CTRL_ADDR, ctl(MODE_CONT, 1'b0, 1'b0, 1'b0));
		wr(CTRL_ADDR, ctl(2'h3, 1'b0, 1'b0, 1'b0));
		#1;
		chk("mode three stops", 32'h0, {31'h0, conv_active});
		rdc("mode three idle", CTRL_ADDR, 32'h0);
		pulse(0);
		pulse(1);
		rdc("idle overflow ignored", STAT_ADDR, 32'h0);
		$display("TEST registers finished");
		new_data();
		wr(CTRL_ADDR, ctl(MODE_SINGLE, 1'b0, 1'b0, 1'b0));
		#1;
		chk("busy set", 32'h1, {31'h0, conv_active});
		run_wait(SLOW_PERIODS * CONV_CYCLES);
		rdc("slow result", SLOW_ADDR, code(slow_d, 1'b0));
		rdc("quick result", QUICK_ADDR, code(quick_d, 1'b0));
		rdc("done only", STAT_ADDR, 32'h2);
		rdc("mode idle", CTRL_ADDR, 32'h0);
		$display("TEST single slow finished");
		v = code(slow_d, 1'b0);
		new_data();
		wr(CTRL_ADDR, ctl(MODE_SINGLE, 1'b1, 1'b0, 1'b0));
		run_wait(CONV_CYCLES);
		rdc("quick overwritten", QUICK_ADDR, code(quick_d, 1'b0));
		rdc("slow untouched", SLOW_ADDR, v);
		rdc("overrun", STAT_ADDR, 32'h32);
		wr(STAT_ADDR, 32'h5F);
		rdc("cleared", STAT_ADDR, 32'h0);
		$display("TEST overrun finished");
		for (int i = 0; i < 7; i++)
		begin
			@(posedge pclk);
			quick_d <= traw[i];
			wr(CTRL_ADDR, ctl(MODE_SINGLE, 1'b1, 1'b0, tpol[i]));
			run_wait(CONV_CYCLES);
			rdc("coding", QUICK_ADDR, {8'h00, texp[i]});
		end
		wr(STAT_ADDR, 32'h5F);
		$display("TEST coding finished");
		new_data();
		wr(CTRL_ADDR, ctl(MODE_CONT, 1'b0, 1'b0, 1'b1));
		pulse(0);
		pulse(1);
		pulse(2);
		repeat (3200) @(posedge pclk);
		chk("still busy", 32'h1, {31'h0, conv_active});
		rdc("cont slow", SLOW_ADDR, code(slow_d, 1'b1));
		rdc("cont quick", QUICK_ADDR, code(quick_d, 1'b1));
		rdc("clips", STAT_ADDR, 32'h6F);
		new_data();
		repeat (1000) @(posedge pclk);
		rdc("cont slow next", SLOW_ADDR, code(slow_d, 1'b1));
		rdc("cont quick next", QUICK_ADDR, code(quick_d, 1'b1));
		rdc("sticky overrun", STAT_ADDR, 32'h7F);
		wr(CTRL_ADDR, ctl(MODE_IDLE, 1'b0, 1'b0, 1'b1));
		#1;
		chk("stopped", 32'h0, {31'h0, conv_active});
		wr(STAT_ADDR, 32'h5F);
		rdc("all cleared", STAT_ADDR, 32'h0);
		$display("TEST continuous finished");
		wr(CTRL_ADDR, ctl(MODE_CONT, 1'b1, 1'b0, 1'b0));
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("busy after reset", 32'h0, {31'h0, conv_active});
		rdc("ctrl after reset", CTRL_ADDR, 32'h0);
		rdc("status after reset", STAT_ADDR, 32'h0);
		$display("TEST mid reset finished");
		close_out();
	end
endmodule
